// ---- design/scr_cfg_mem.sv ----
// stored configuration memory with registered read data
`timescale 1ns/1ps
module scr_cfg_mem #(
   parameter int                   WIDTH = 16,
   parameter int                   DEPTH = 4,
   parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     rd_en,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data_r
);
   // ----------------------------------------
   // read port
   // ----------------------------------------
   // contents are fixed at build time, as a one-time store would be
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= '0;
      end else if (rd_en) begin
         rd_data_r <= INIT[rd_addr*WIDTH +: WIDTH];
      end
   end
endmodule

// ---- design/scr_pkg.sv ----
// shared constants and types for start-up configuration and reference select
package scr_pkg;
   // ----------------------------------------
   // register map (byte addresses on the serial-bus register port)
   // ----------------------------------------
   localparam logic [7:0] ADDR_LOAD_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_SRC_POL    = 8'h13;
   localparam int         BIT_LOAD_OTP    = 7;
   localparam int         BIT_PRIM_SRC    = 1;
   localparam int         BIT_SM_HI       = 7;
   localparam int         BIT_SM_LO       = 6;
   localparam logic [7:0] RST_LOAD_CTRL   = 8'h00;
   localparam logic [7:0] RST_SRC_POL     = 8'h00;
   // serial-bus defaults used in software mode when the load-control flag asks for them
   localparam logic [7:0] SWDEF_LOAD_CTRL = 8'h80;
   localparam logic [7:0] SWDEF_SRC_POL   = 8'h00;
   // ----------------------------------------
   // stored configurations
   // ----------------------------------------
   localparam int          CFG_W     = 16;
   localparam int          CFG_N     = 4;
   localparam logic [63:0] CFG_IMAGE = 64'h0000_0001_0002_0003;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ      = 20;
   localparam int SETTLE_US    = 1000;
   localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
   localparam int SWITCH_GAP   = 4;
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_STRAP  = 3'b000,
      ST_FETCH  = 3'b001,
      ST_APPLY  = 3'b010,
      ST_SETTLE = 3'b011,
      ST_RUN    = 3'b100
   } scr_state_e_t;
endpackage

// ---- design/scr_top.sv ----
// start-up mode capture, configuration loading and reference source selection
`timescale 1ns/1ps
module scr_top
   import scr_pkg::*;
#(
   parameter int SETTLE_CYCLES = scr_pkg::SETTLE_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       mode_strap_pin,
   input  wire logic       config_select_bit0,
   input  wire logic       config_select_bit1,
   input  wire logic       source_select_pin,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata_r,
   output logic            reg_ack_r,
   output logic            mode_hw_r,
   output logic      [1:0] cfg_index_r,
   output logic            cfg_busy_r,
   output logic            div_sync_r,
   output logic      [7:0] otp_load_control_r,
   output logic      [7:0] input_source_polarity_r,
   output logic            ref_is_diff_r,
   output logic            xtal_en_r,
   output logic            diff_en_r
);
   import scr_pkg::*;

   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam int GW = $clog2(SWITCH_GAP + 1);

   typedef struct packed {
      scr_state_e_t st;
      logic         mode_hw;
      logic [1:0]   cfg_idx;
      logic [7:0]   otp_load_control;
      logic [7:0]   reg13;
      logic [7:0]   rdata;
      logic         ack;
      logic         div_sync;
      logic         busy;
      logic [CW-1:0] settle;
      logic         ref_sel;
      logic         xtal_en;
      logic         diff_en;
      logic [GW-1:0] gap;
   } scr_regs_t;

   scr_regs_t         s_r;
   scr_regs_t         s_nxt;
   logic [CFG_W-1:0]  mem_data;
   logic [1:0]        sel_pins;
   logic              want_diff;

   // 0 = unmapped, 1 = load control, 2 = source polarity
   function automatic logic [1:0] decode(input logic [7:0] a);
      if (a == ADDR_LOAD_CTRL) begin
         decode = 2'h1;
      end else if (a == ADDR_SRC_POL) begin
         decode = 2'h2;
      end else begin
         decode = 2'h0;
      end
   endfunction

   // ----------------------------------------
   // stored configurations
   // ----------------------------------------
   scr_cfg_mem #(
      .WIDTH (CFG_W),
      .DEPTH (CFG_N),
      .INIT  (CFG_IMAGE)
   ) u_mem (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .rd_en     (s_r.st == ST_FETCH),
      .rd_addr   (s_r.cfg_idx),
      .rd_data_r (mem_data)
   );

   assign sel_pins  = {config_select_bit1, config_select_bit0};
   // automatic mode holds the current source; only manual follows the pin
   assign want_diff = s_r.reg13[BIT_SM_HI] ? s_r.ref_sel
                      : (s_r.reg13[BIT_PRIM_SRC] ^ source_select_pin);

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      s_nxt          = s_r;
      s_nxt.div_sync = 1'b0;
      s_nxt.ack      = 1'b0;
      case (s_r.st)
         ST_STRAP: begin
            s_nxt.mode_hw = mode_strap_pin;
            s_nxt.cfg_idx = mode_strap_pin ? sel_pins : 2'h0;
            s_nxt.st      = ST_FETCH;
         end
         ST_FETCH: begin
            s_nxt.st = ST_APPLY;
         end
         ST_APPLY: begin
            if (!s_r.mode_hw && mem_data[8 + BIT_LOAD_OTP]) begin
               s_nxt.otp_load_control  = SWDEF_LOAD_CTRL;
               s_nxt.reg13 = SWDEF_SRC_POL;
            end else begin
               s_nxt.otp_load_control  = mem_data[15:8];
               s_nxt.reg13 = mem_data[7:0];
            end
            if (s_r.mode_hw) begin
               s_nxt.div_sync = 1'b1;
               s_nxt.settle   = CW'(SETTLE_CYCLES);
               s_nxt.st       = ST_SETTLE;
            end else begin
               s_nxt.busy = 1'b0;
               s_nxt.st   = ST_RUN;
            end
         end
         ST_SETTLE: begin
            // pin moves during settling are caught when run resumes
            if (s_r.settle <= CW'(1)) begin
               s_nxt.busy = 1'b0;
               s_nxt.st   = ST_RUN;
            end
            s_nxt.settle = s_r.settle - CW'(1);
         end
         ST_RUN: begin
            if (s_r.mode_hw && sel_pins != s_r.cfg_idx) begin
               s_nxt.cfg_idx = sel_pins;
               s_nxt.busy    = 1'b1;
               s_nxt.st      = ST_FETCH;
            end
         end
         default: begin
            s_nxt.st = ST_STRAP;
         end
      endcase
      // register port: open in software mode once booted, closed in hardware mode
      if ((reg_wr || reg_rd) && s_r.st == ST_RUN && !s_r.mode_hw) begin
         s_nxt.ack = 1'b1;
         if (reg_wr && decode(reg_addr) == 2'h1) begin
            s_nxt.otp_load_control = reg_wdata;
         end else if (reg_wr && decode(reg_addr) == 2'h2) begin
            s_nxt.reg13 = reg_wdata;
         end
      end
      if (reg_rd) begin
         if (s_r.mode_hw || s_r.st != ST_RUN) begin
            s_nxt.rdata = 8'h00;
         end else if (decode(reg_addr) == 2'h1) begin
            s_nxt.rdata = s_r.otp_load_control;
         end else if (decode(reg_addr) == 2'h2) begin
            s_nxt.rdata = s_r.reg13;
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
      // break-before-make: both references off for a gap before the new one
      if (s_r.gap != '0) begin
         s_nxt.gap = s_r.gap - GW'(1);
         if (s_r.gap == GW'(1)) begin
            s_nxt.xtal_en = !s_r.ref_sel;
            s_nxt.diff_en = s_r.ref_sel;
         end
      end else if (want_diff != s_r.ref_sel) begin
         s_nxt.ref_sel = want_diff;
         s_nxt.xtal_en = 1'b0;
         s_nxt.diff_en = 1'b0;
         s_nxt.gap     = GW'(SWITCH_GAP);
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r          <= '0;
         s_r.st       <= ST_STRAP;
         s_r.otp_load_control     <= RST_LOAD_CTRL;
         s_r.reg13    <= RST_SRC_POL;
         s_r.busy     <= 1'b1;
         s_r.xtal_en  <= 1'b1; // crystal is the default source
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_r             = s_r.rdata;
   assign reg_ack_r               = s_r.ack;
   assign mode_hw_r               = s_r.mode_hw;
   assign cfg_index_r             = s_r.cfg_idx;
   assign cfg_busy_r              = s_r.busy;
   assign div_sync_r              = s_r.div_sync;
   assign otp_load_control_r      = s_r.otp_load_control;
   assign input_source_polarity_r = s_r.reg13;
   assign ref_is_diff_r           = s_r.ref_sel;
   assign xtal_en_r               = s_r.xtal_en;
   assign diff_en_r               = s_r.diff_en;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_mode_latched: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.st != ST_STRAP |=> $stable(mode_hw_r))
      else $error("mode changed after strap capture");
   a_strap_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && s_r.st == ST_STRAP |=> mode_hw_r == $past(mode_strap_pin))
      else $error("strap level not captured");
   a_hw_write_denied: assert property (@(posedge core_clk) disable iff (!rst_n)
      (mode_hw_r && s_r.st == ST_RUN && reg_wr) |=> $stable(s_r.reg13) && !reg_ack_r)
      else $error("register write accepted in hardware mode");
   a_sw_write_open: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!mode_hw_r && s_r.st == ST_RUN && reg_wr && reg_addr == ADDR_SRC_POL)
      |=> input_source_polarity_r == $past(reg_wdata) && reg_ack_r)
      else $error("software write to polarity register lost");
   a_sel_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
      (mode_hw_r && s_r.st == ST_RUN && sel_pins != cfg_index_r)
      |=> cfg_busy_r ##1 1'b1 ##1 div_sync_r && cfg_index_r == $past(sel_pins, 3))
      else $error("select change did not reload and sync");
   a_sync_hw_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      div_sync_r |-> mode_hw_r && s_r.st == ST_SETTLE)
      else $error("divider sync outside hardware load");
   a_no_overlap: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(xtal_en_r && diff_en_r) and ($rose(diff_en_r) |-> $past(!xtal_en_r, 2)))
      else $error("references enabled together or without gap");
   a_source_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!input_source_polarity_r[BIT_SM_HI] && s_r.gap == '0
       && (input_source_polarity_r[BIT_PRIM_SRC] ^ source_select_pin) != ref_is_diff_r)
      |=> ref_is_diff_r == $past(want_diff) ##[1:8] (diff_en_r == ref_is_diff_r))
      else $error("source select not followed");
endmodule

// ---- verification/scr_host_model.sv ----
// host model: strap, select and source pins plus register strobes
`timescale 1ns/1ps
module scr_host_model (
   input  wire logic       core_clk,
   output logic            mode_strap_pin,
   output logic            config_select_bit0,
   output logic            config_select_bit1,
   output logic            source_select_pin,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // ----------------------------------------
   // pin and strobe drivers
   // ----------------------------------------
   // all idle at time zero; pins move only when a task asks
   initial begin
      {mode_strap_pin, config_select_bit1, config_select_bit0} = 3'h0;
      {source_select_pin, reg_wr, reg_rd} = 3'h0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end
   // boot levels are set before reset and then left alone through it
   task automatic set_boot(input logic strap, input logic [1:0] sel);
      @(posedge core_clk);
      mode_strap_pin     <= strap;
      config_select_bit1 <= sel[1];
      config_select_bit0 <= sel[0];
   endtask
   // one pin per call; the caller waits out settling before the next
   task automatic flip_sel(input logic msb);
      @(posedge core_clk);
      if (msb) config_select_bit1 <= ~config_select_bit1;
      else config_select_bit0 <= ~config_select_bit0;
   endtask
   task automatic set_src(input logic v);
      @(posedge core_clk);
      source_select_pin <= v;
   endtask
   // one-cycle strobe; idle bus shows the inverse so stale data cannot pass
   task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= wr;
      reg_rd    <= ~wr;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

// ---- verification/scr_top_tb_top.sv ----
// self-checking bench for start-up configuration and reference select
`timescale 1ns/1ps
module scr_top_tb_top;
   import scr_pkg::*;
   logic       core_clk, rst_n, mode_strap_pin, config_select_bit0, config_select_bit1;
   logic       source_select_pin, reg_wr, reg_rd, reg_ack_r, mode_hw_r, cfg_busy_r;
   logic       div_sync_r, ref_is_diff_r, xtal_en_r, diff_en_r;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r, otp_load_control_r, input_source_polarity_r;
   logic [1:0] cfg_index_r;
   int         err_total, check_count, sync_cnt;
   scr_top #(.SETTLE_CYCLES(8)) scr_top_inst (.core_clk, .rst_n, .mode_strap_pin,
      .config_select_bit0, .config_select_bit1, .source_select_pin, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata_r, .reg_ack_r, .mode_hw_r, .cfg_index_r,
      .cfg_busy_r, .div_sync_r, .otp_load_control_r, .input_source_polarity_r,
      .ref_is_diff_r, .xtal_en_r, .diff_en_r);
   scr_host_model scr_host_model_inst (.core_clk, .mode_strap_pin, .config_select_bit0,
      .config_select_bit1, .source_select_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   // ----------------------------------------
   // clock, monitors and helpers
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // count divider sync pulses; both reference gates open is never allowed
   always @(posedge core_clk) begin
      if (div_sync_r === 1'b1) sync_cnt <= sync_cnt + 1;
      if (xtal_en_r === 1'b1 && diff_en_r === 1'b1) begin
         $display("[FAIL] gate overlap exp 0 got 1");
         err_total <= err_total + 1;
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         $display("[FAIL] %s exp %0h got %0h", n, e, g);
         err_total++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic do_reset(input logic strap, input logic [1:0] sel);
      scr_host_model_inst.set_boot(strap, sel);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      sync_cnt = 0;
      rst_n <= 1'b1;
   endtask
   // bounded wait for the loader to go idle
   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         @(posedge core_clk);
         #1;
         if (cfg_busy_r === 1'b0) return;
      end
      chk("busy timeout", 8'h00, 8'h01);
      end_of_test();
   endtask
   // an access: ack and, for reads, data are seen one cycle after the strobe
   task automatic acc(input logic wr, input logic [7:0] a, d, input logic ak, input logic [7:0] q);
      scr_host_model_inst.reg_op(wr, a, d);
      #1;
      chk("ack", {7'h00, ak}, {7'h00, reg_ack_r});
      if (!wr) chk("rdata", q, reg_rdata_r);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_sw_boot();
      do_reset(1'b0, 2'b11);
      wait_idle();
      chk("mode", 8'h00, {7'h00, mode_hw_r});
      chk("otp_load_control", CFG_IMAGE[15:8], otp_load_control_r);
      chk("reg13", CFG_IMAGE[7:0], input_source_polarity_r);
      chk("sync", 8'h00, sync_cnt[7:0]);
      // the loaded polarity moves the source one edge later, then the gap runs out
      repeat (SWITCH_GAP + 1) @(posedge core_clk);
      #1;
      chk("src", {7'h00, CFG_IMAGE[1] ^ source_select_pin}, {7'h00, ref_is_diff_r});
      chk("diff on", 8'h01, {7'h00, diff_en_r});
      chk("xtal off", 8'h00, {7'h00, xtal_en_r});
   endtask
   task automatic t_regs();
      acc(1'b1, ADDR_SRC_POL, 8'h02, 1'b1, 8'h00);
      acc(1'b0, ADDR_SRC_POL, 8'h00, 1'b1, 8'h02);
      acc(1'b1, ADDR_LOAD_CTRL, 8'h80, 1'b1, 8'h00);
      acc(1'b0, ADDR_LOAD_CTRL, 8'h00, 1'b1, 8'h80);
      acc(1'b0, 8'h55, 8'h00, 1'b1, 8'h00);
   endtask
   // polarity 1, pin to 1: crystal after a break with both gates shut
   task automatic t_switch();
      int n;
      scr_host_model_inst.set_src(1'b1);
      // look a step after each edge so the gate value launched there is settled
      for (n = 1; n < 12 && xtal_en_r !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk("src", 8'h00, {7'h00, ref_is_diff_r});
      chk("gap ok", 8'h01, {7'h00, n > 2 && n <= SWITCH_GAP + 2});
      acc(1'b1, ADDR_SRC_POL, 8'h82, 1'b1, 8'h00);
      scr_host_model_inst.set_src(1'b0);
      repeat (SWITCH_GAP + 4) @(posedge core_clk);
      #1;
      chk("auto hold", 8'h00, {7'h00, ref_is_diff_r});
      chk("xtal on", 8'h01, {7'h00, xtal_en_r});
   endtask
   task automatic t_strap_hold();
      scr_host_model_inst.set_boot(1'b1, 2'b11);
      repeat (5) @(posedge core_clk);
      #1;
      chk("mode held", 8'h00, {7'h00, mode_hw_r});
   endtask
   task automatic t_hw();
      do_reset(1'b1, 2'b10);
      wait_idle();
      chk("mode", 8'h01, {7'h00, mode_hw_r});
      chk("index", 8'h02, {6'h00, cfg_index_r});
      chk("otp_load_control", CFG_IMAGE[47:40], otp_load_control_r);
      chk("reg13", CFG_IMAGE[39:32], input_source_polarity_r);
      chk("sync", 8'h01, sync_cnt[7:0]);
      acc(1'b1, ADDR_SRC_POL, 8'hFF, 1'b0, 8'h00);
      chk("denied", CFG_IMAGE[39:32], input_source_polarity_r);
      acc(1'b0, ADDR_SRC_POL, 8'h00, 1'b0, 8'h00);
      sync_cnt = 0;
      scr_host_model_inst.flip_sel(1'b0);
      repeat (2) @(posedge core_clk);
      wait_idle();
      chk("index", 8'h03, {6'h00, cfg_index_r});
      chk("reg13", CFG_IMAGE[55:48], input_source_polarity_r);
      chk("sync", 8'h01, sync_cnt[7:0]);
   endtask
   initial begin
      rst_n       = 1'b0;
      err_total   = 0;
      check_count = 0;
      sync_cnt    = 0;
      t_sw_boot();
      t_regs();
      t_switch();
      t_strap_hold();
      t_hw();
      end_of_test();
   end
endmodule
